// [sto_pkg.sv]
// package: constants and types for the safe torque off supervisor
package sto_pkg;

    // ------------------------------------------------------------
    // fault codes recorded in the fault log
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_CH_ONE = 8'h48;
    localparam logic [7:0] CODE_TORQUE_OFF = 8'h4C;
    localparam logic [7:0] CODE_CH_TWO = 8'h4D;
    localparam logic [7:0] CODE_INTERNAL = 8'h4E;

    // ------------------------------------------------------------
    // policy values and timing
    // ------------------------------------------------------------
    localparam logic LATCH_POLICY_LATCH = 1'b0;
    localparam logic LATCH_POLICY_AUTO = 1'b1;
    localparam int CLK_HZ = 25000000;
    localparam int RESPONSE_MS = 20;
    localparam int RESPONSE_CYCLES = CLK_HZ / 1000 * RESPONSE_MS;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        ALARM_NONE,
        ALARM_TORQUE_OFF,
        ALARM_CH_ONE,
        ALARM_CH_TWO,
        ALARM_INTERNAL
    } alarm_t;

    typedef struct packed {
        logic channel_one;
        logic channel_two;
    } channels_t;

    typedef struct packed {
        logic combined_torque_off_alarm;
        logic channel_one_loop_fault;
        logic channel_two_loop_fault;
        logic internal_loop_fault;
    } alarms_t;

endpackage

// [channel_sync.sv]
// two-flop synchroniser for both safety channels
`timescale 1ns/1ps
module channel_sync (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire sto_pkg::channels_t raw_in,
    output sto_pkg::channels_t sync_out
);
    import sto_pkg::*;

    channels_t meta_q;

    // reset to inactive so torque stays off until real samples arrive
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_out <= '0;
        end else if (clk_en_in) begin
            meta_q <= raw_in;
            sync_out <= meta_q;
        end
    end
endmodule

// [safe_torque_off_monitor.sv]
// safe torque off supervisor: channel decode, alarm latching, torque gate
// What this block does
// - both channels inactive: torque off, combined alarm
// - channel one only inactive: channel-one fault
// - channel two only inactive: channel-two fault
// - self-check error reports internal loop fault
// - both active: no alarm, follow run
// - torque removed within 20 ms
// - latch policy 0 latches the combined alarm, 1 not
// - policy 0: combined alarm needs reset
// - policy 1: combined alarm clears itself
// - channel and internal faults always latch
// - channel faults clear only by power cycle
// - restart option resumes run after clear, under policy 0 only
// - fault log codes 72, 76, 77, 78
`timescale 1ns/1ps
module safe_torque_off_monitor (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic safety_channel_one_in,
    input wire logic safety_channel_two_in,
    input wire logic self_check_error_in,
    input wire logic run_command_in,
    input wire logic operator_reset_in,
    input wire logic alarm_latch_policy_in,
    input wire logic restart_after_reset_option_in,
    output logic torque_enable_out,
    output sto_pkg::alarms_t alarms_out,
    output sto_pkg::alarm_t alarm_state_out,
    output logic [7:0] fault_code_out,
    output logic fault_log_strobe_out
);
    import sto_pkg::*;

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    channels_t raw;
    channels_t chan;
    logic sampled_q;
    logic [1:0] fill_q;
    logic sto_q;
    logic channel_one_loop_fault_q;
    logic channel_two_loop_fault_q;
    logic internal_loop_fault_q;
    logic run_block_q;
    logic clearing;
    logic any_alarm;
    alarm_t state_d;
    logic [7:0] code_d;

    assign raw.channel_one = safety_channel_one_in;
    assign raw.channel_two = safety_channel_two_in;

    channel_sync u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .raw_in(raw),
        .sync_out(chan)
    );

    // hold off until pipeline filled
    // sync flops reset inactive; decoding them early latches a false alarm
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fill_q <= 2'h0;
            sampled_q <= 1'b0;
        end else if (clk_en_in && !sampled_q) begin
            fill_q <= fill_q + 2'h1;
            if (fill_q == 2'(SYNC_STAGES - 1)) begin
                sampled_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // alarm latches
    // ------------------------------------------------------------
    // combined alarm; set wins over any clear
    // policy input picks latch or auto clear
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sto_q <= 1'b0;
        end else if (clk_en_in && sampled_q) begin
            if (!chan.channel_one && !chan.channel_two) begin
                sto_q <= 1'b1;
            end else if (alarm_latch_policy_in == LATCH_POLICY_AUTO && chan.channel_one && chan.channel_two) begin
                sto_q <= 1'b0;
            end else if (operator_reset_in && chan.channel_one && chan.channel_two) begin
                sto_q <= 1'b0;
            end
        end
    end

    // single-channel and internal faults always latch
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_one_loop_fault_q <= 1'b0;
            channel_two_loop_fault_q <= 1'b0;
        end else if (clk_en_in && sampled_q) begin
            if (!chan.channel_one && chan.channel_two) begin
                channel_one_loop_fault_q <= 1'b1;
            end
            if (chan.channel_one && !chan.channel_two) begin
                channel_two_loop_fault_q <= 1'b1;
            end
        end
    end

    // self-check failure, kept until power cycle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            internal_loop_fault_q <= 1'b0;
        end else if (clk_en_in && sampled_q) begin
            if (self_check_error_in) begin
                internal_loop_fault_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // run gating
    // ------------------------------------------------------------
    assign any_alarm = sto_q || channel_one_loop_fault_q || channel_two_loop_fault_q || internal_loop_fault_q;
    assign clearing = sto_q && !channel_one_loop_fault_q && !channel_two_loop_fault_q && !internal_loop_fault_q && chan.channel_one && chan.channel_two
        && (operator_reset_in || alarm_latch_policy_in == LATCH_POLICY_AUTO);

    // a held run command must be released first unless restart is allowed under policy 0
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_block_q <= 1'b0;
        end else if (clk_en_in) begin
            if (clearing) begin
                run_block_q <= (restart_after_reset_option_in == 1'b0)
                    || (alarm_latch_policy_in == LATCH_POLICY_AUTO);
            end else if (!run_command_in) begin
                run_block_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // torque gate
    // ------------------------------------------------------------
    // one-cycle decode, far inside the response time
    // run command and restart block steer output when healthy
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            torque_enable_out <= 1'b0;
        end else if (clk_en_in) begin
            torque_enable_out <= sampled_q && chan.channel_one && chan.channel_two && !any_alarm
                && run_command_in && !run_block_q && !clearing;
        end
    end

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    // internal fault reported first
    always_comb begin
        state_d = ALARM_NONE;
        code_d = CODE_NONE;
        if (internal_loop_fault_q) begin
            state_d = ALARM_INTERNAL;
            code_d = CODE_INTERNAL;
        end else if (channel_one_loop_fault_q) begin
            state_d = ALARM_CH_ONE;
            code_d = CODE_CH_ONE;
        end else if (channel_two_loop_fault_q) begin
            state_d = ALARM_CH_TWO;
            code_d = CODE_CH_TWO;
        end else if (sto_q) begin
            state_d = ALARM_TORQUE_OFF;
            code_d = CODE_TORQUE_OFF;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            alarm_state_out <= ALARM_NONE;
        end else if (clk_en_in) begin
            alarm_state_out <= state_d;
        end
    end

    // log code moves with the state
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_code_out <= CODE_NONE;
        end else if (clk_en_in) begin
            fault_code_out <= code_d;
        end
    end

    // log strobe on change to a fault
    // one cycle only, so each change to a fault code is logged once
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_log_strobe_out <= 1'b0;
        end else if (clk_en_in) begin
            fault_log_strobe_out <= (code_d != fault_code_out) && (code_d != CODE_NONE);
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            alarms_out <= '0;
        end else if (clk_en_in) begin
            alarms_out <= '{sto_q, channel_one_loop_fault_q, channel_two_loop_fault_q, internal_loop_fault_q};
        end
    end
endmodule

// [safe_torque_off_monitor_asserts.sv]
// checker: port assertions for the safe torque off supervisor
`timescale 1ns/1ps
module sto_checker import sto_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic safety_channel_one_in,
    input wire logic safety_channel_two_in,
    input wire logic self_check_error_in,
    input wire logic torque_enable_out,
    input wire alarms_t alarms_out,
    input wire alarm_t alarm_state_out,
    input wire logic [7:0] fault_code_out,
    input wire logic fault_log_strobe_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    a_torque_cut: assert property (!(safety_channel_one_in && safety_channel_two_in) |-> ##[1:3] !torque_enable_out)
        else $error("torque not cut");
    a_code_off: assert property (alarm_state_out == ALARM_TORQUE_OFF |-> fault_code_out == CODE_TORQUE_OFF)
        else $error("bad code");
    a_code_one: assert property (alarm_state_out == ALARM_CH_ONE |-> fault_code_out == CODE_CH_ONE)
        else $error("bad code");
    a_code_two: assert property (alarm_state_out == ALARM_CH_TWO |-> fault_code_out == CODE_CH_TWO)
        else $error("bad code");
    a_code_int: assert property (alarm_state_out == ALARM_INTERNAL |-> fault_code_out == CODE_INTERNAL)
        else $error("bad code");
    a_int_prio: assert property (self_check_error_in |-> ##[1:4] alarm_state_out == ALARM_INTERNAL)
        else $error("no internal");
    a_fault_keep: assert property (!$fell(alarms_out.channel_one_loop_fault) && !$fell(alarms_out.channel_two_loop_fault))
        else $error("fault cleared");
    a_fault_off: assert property (alarms_out.channel_one_loop_fault || alarms_out.channel_two_loop_fault |-> !torque_enable_out)
        else $error("torque in fault");
    a_strobe_once: assert property (fault_log_strobe_out |=> !fault_log_strobe_out)
        else $error("long strobe");
    cover property (alarm_state_out == ALARM_TORQUE_OFF);
    cover property (alarm_state_out == ALARM_CH_TWO);
    cover property (alarm_state_out == ALARM_INTERNAL);
endmodule
bind safe_torque_off_monitor sto_checker u_sto_checker (.*);

// [contact_model.sv]
// partner: emergency stop contacts feeding both channels
`timescale 1ns/1ps
module contact_model (
    input wire logic ref_clk_in,
    input wire logic open_one_in,
    input wire logic open_two_in,
    output sto_pkg::channels_t contacts_out
);
    always_ff @(posedge ref_clk_in) begin
        contacts_out <= {!open_one_in, !open_two_in};
    end
endmodule

// [safe_torque_off_monitor_tb.sv]
// testbench: safe torque off supervisor scenarios
`timescale 1ns/1ps
module safe_torque_off_monitor_tb;
    import sto_pkg::*;
    logic clk = 0, rst = 1, op1 = 0, op2 = 0, serr = 0, run = 0, ores = 0, pol = 0, rso = 0, ten, stb;
    int num_errors = 0, cmp_count = 0;
    channels_t ch;
    alarms_t al;
    alarm_t st;
    logic [7:0] code;
    always #20 clk = ~clk;
    contact_model u_contact_model (.ref_clk_in(clk), .open_one_in(op1), .open_two_in(op2), .contacts_out(ch));
    safe_torque_off_monitor u_safe_torque_off_monitor (.ref_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1),
        .safety_channel_one_in(ch.channel_one), .safety_channel_two_in(ch.channel_two),
        .self_check_error_in(serr), .run_command_in(run), .operator_reset_in(ores),
        .alarm_latch_policy_in(pol), .restart_after_reset_option_in(rso), .torque_enable_out(ten),
        .alarms_out(al), .alarm_state_out(st), .fault_code_out(code), .fault_log_strobe_out(stb));
    task automatic complete_run;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_ten(input logic v);
        for (int i = 0; i < 50 && ten !== v; i++) @(negedge clk);
        chk(8'(ten), 8'(v));
        if (ten !== v)
            complete_run();
    endtask
    task automatic pwr;
        @(posedge clk) rst <= 1;
        repeat (4) @(posedge clk);
        rst <= 0;
    endtask
    task automatic pulse_reset;
        @(posedge clk) ores <= 1;
        @(posedge clk) ores <= 0;
    endtask
    task automatic t_normal;
        @(posedge clk) run <= 1;
        wait_ten(1);
        chk(8'(st), 8'(ALARM_NONE));
        @(posedge clk) run <= 0;
        wait_ten(0);
    endtask
    // latched combined alarm, both restart options
    task automatic t_latch(input logic opt);
        @(posedge clk) {run, rso} <= {1'b1, opt};
        wait_ten(1);
        @(posedge clk) {op1, op2} <= 2'b11;
        wait_ten(0);
        cyc(1);
        chk(8'(stb), 8'h01);
        chk(8'(al), 8'h08);
        cyc(1);
        chk(8'(stb), 8'h00);
        chk(8'(st), 8'(ALARM_TORQUE_OFF));
        @(posedge clk) {op1, op2} <= 2'b00;
        cyc(8);
        chk(8'(st), 8'(ALARM_TORQUE_OFF));
        pulse_reset();
        cyc(8);
        chk(8'(st), 8'(ALARM_NONE));
        chk(8'(ten), 8'(opt));
        @(posedge clk) {run, rso} <= 2'b00;
        wait_ten(0);
    endtask
    task automatic t_auto;
        @(posedge clk) {run, pol} <= 2'b11;
        wait_ten(1);
        @(posedge clk) {op1, op2} <= 2'b11;
        wait_ten(0);
        @(posedge clk) {op1, op2} <= 2'b00;
        cyc(8);
        chk(8'(st), 8'(ALARM_NONE));
        @(posedge clk) {run, pol} <= 2'b00;
    endtask
    // single-channel faults survive keypad reset
    task automatic t_single(input logic o1, input logic o2, input alarm_t es, input logic [7:0] ec);
        @(posedge clk) run <= 1;
        wait_ten(1);
        @(posedge clk) {op1, op2, pol} <= {o1, o2, 1'b1};
        wait_ten(0);
        cyc(2);
        chk(8'(st), 8'(es));
        chk(code, ec);
        chk(8'(al), (es == ALARM_CH_ONE) ? 8'h04 : 8'h02);
        @(posedge clk) {op1, op2, run} <= 3'b000;
        pulse_reset();
        cyc(8);
        chk(8'(st), 8'(es));
        pwr();
        cyc(2);
        chk(8'(st), 8'(ALARM_NONE));
        chk(8'(al), 8'h00);
        @(posedge clk) pol <= 0;
    endtask
    task automatic t_internal;
        @(posedge clk) {serr, op1} <= 2'b11;
        cyc(8);
        chk(8'(st), 8'(ALARM_INTERNAL));
        chk(code, CODE_INTERNAL);
        chk(8'(ten), 8'h00);
        @(posedge clk) {serr, op1} <= 2'b00;
        pwr();
    endtask
    initial begin
        pwr();
        t_normal();
        t_latch(0);
        t_latch(1);
        t_auto();
        t_single(1, 0, ALARM_CH_ONE, CODE_CH_ONE);
        t_single(0, 1, ALARM_CH_TWO, CODE_CH_TWO);
        t_internal();
        complete_run();
    end
endmodule
